// ### hw/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ==========================================
// register offsets (byte addresses)
`define SSR_A_SEL       8'h00
`define SSR_A_LIMIT     8'h04
`define SSR_A_GAIN      8'h08
`define SSR_A_RESTART   8'h0C
`define SSR_A_CMD       8'h10
`define SSR_A_STATUS    8'h14
`define SSR_A_IRQ_STAT  8'h18
`define SSR_A_IRQ_MASK  8'h1C

// ==========================================
// field positions
`define SSR_F_TSEL_LO   8
`define SSR_F_RSEL_LO   16
`define SSR_F_RATED_LO  16
`define SSR_F_KI_LO     16
`define SSR_F_DELAY_LO  16

// ==========================================
// reset values and ranges
`define SSR_RST_SEL     4'h0
`define SSR_RST_TSEL    5'h0C
`define SSR_RST_RSEL    5'h11
`define SSR_RST_LIMIT   8'h64
`define SSR_MIN_LIMIT   8'h50
`define SSR_MAX_LIMIT   8'hC8
`define SSR_RST_RATED   16'h0064
`define SSR_RST_KP      14'h0064
`define SSR_RST_KI      14'h03E8
`define SSR_MAX_GAIN    14'h270F
`define SSR_RST_COUNT   4'h0
`define SSR_MAX_COUNT   4'hA
`define SSR_RST_DELAY   10'h00A
`define SSR_MAX_DELAY   10'h258
`define SSR_MAX_OSEL    5'h14
`define SSR_OSEL_SEARCH 5'h0F
`define SSR_PERCENT     24'h00_0064

// ==========================================
// timing: one tick is 0.1 s
`define SSR_CLK_NS      32'h0000_0014
`define SSR_TICK_NS     32'h05F5_E100
`define SSR_TRIPFREE    10'h12C
`define SSR_FREQ_STEP   16'h0001

`endif

// ### hw/ssr_pkg.sv
package ssr_pkg;

  typedef enum logic [2:0] {
    SSR_IDLE   = 3'b000,
    SSR_RUN    = 3'b001,
    SSR_SEARCH = 3'b010,
    SSR_HOLD   = 3'b011,
    SSR_TRIP   = 3'b100,
    SSR_LOCK   = 3'b101
  } ssr_state_t;

  typedef logic [5:0] ssr_irq_t;

endpackage

// ### hw/ssr_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_timer #(
  parameter int TICK_CYC = 5000000,
  parameter int W        = 10
) (
  input  wire logic         clk,     // system clock
  input  wire logic         rst_n,   // async reset, low
  input  wire logic         start,   // load and run
  input  wire logic [W-1:0] load,    // ticks to wait
  input  wire logic         cancel,  // abandon the wait
  output logic              busy,    // wait in progress
  output logic              done     // one-cycle expiry pulse
);

  logic [31:0]  pre;
  logic [W-1:0] left;

  // refuse a tick or width that the counters cannot serve
  if (TICK_CYC < 1 || W < 1) begin : g_bad_param
    $error("ssr_timer: bad parameters");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre  <= '0;
      left <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cancel) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        left <= load;
        pre  <= '0;
      end else if (busy) begin
        if (left == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (pre == 32'(TICK_CYC - 1)) begin
          pre  <= '0;
          left <= left - 1'b1;
        end else begin
          pre <= pre + 32'h0000_0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### hw/ssr_core.sv
// Local design decisions: the APB slave port and the register addresses.
`include "ssr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ssr_core
  import ssr_pkg::*;
#(
  parameter int TICK_CYC = `SSR_TICK_NS / `SSR_CLK_NS
) (
  input  wire logic        pclk,                     // system clock
  input  wire logic        presetn,                  // async reset, low
  input  wire logic [7:0]  paddr,                    // apb address
  input  wire logic        psel,                     // apb select
  input  wire logic        penable,                  // apb enable
  input  wire logic        pwrite,                   // apb direction
  input  wire logic [31:0] pwdata,                   // apb write data
  output logic      [31:0] prdata,                   // apb read data
  output logic             pready,                   // apb ready
  output logic             pslverr,                  // apb error
  input  wire logic [15:0] output_current,           // measured output current
  input  wire logic [15:0] target_freq,              // commanded frequency
  input  wire logic [15:0] nominal_volt,             // voltage for the frequency
  input  wire logic        run_cmd,                  // run request level
  input  wire logic        power_on_start,           // pulse after power-on
  input  wire logic        power_lost,               // input power missing
  input  wire logic        trip_fault,               // protective trip pulse
  input  wire logic        emergency_stop_input,     // emergency stop level
  input  wire logic        fault_reset_input,        // terminal reset pulse
  input  wire logic        keypad_reset,             // stop/reset key pulse
  output logic      [15:0] out_freq,                 // output frequency
  output logic      [15:0] out_volt,                 // output voltage
  output logic             output_hold,              // output frozen or off
  output logic             undervoltage_trip,        // low voltage trip
  output logic             search_active,            // search in progress
  output logic             transistor_status_output, // transistor output
  output logic             relay_status_output,      // relay output
  output logic             irq                       // interrupt level
);

  // ==========================================
  // configuration and state
  logic [3:0]  search_trigger_select;
  logic [4:0]  transistor_output_select;
  logic [4:0]  relay_output_select;
  logic [7:0]  search_current_limit;
  logic [15:0] motor_rated_current;
  logic [13:0] search_prop_gain;
  logic [13:0] search_integral_gain;
  logic [3:0]  restart_attempt_count;
  logic [9:0]  restart_delay_time;
  logic [3:0]  remaining;
  logic        auto_off;
  logic [15:0] saved_freq;
  logic        resume_hold;
  logic [31:0] integ;
  ssr_irq_t    irq_stat;
  ssr_irq_t    irq_mask;
  ssr_state_t  state;
  ssr_state_t  next_state;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic flags_search(input logic [4:0] osel);
    flags_search = (osel == `SSR_OSEL_SEARCH);
  endfunction

  // ==========================================
  // apb decode
  wire wr_en    = psel && penable && pready && pwrite;
  wire rd_en    = psel && penable && pready && !pwrite;
  wire a_sel    = (paddr == `SSR_A_SEL);
  wire a_limit  = (paddr == `SSR_A_LIMIT);
  wire a_gain   = (paddr == `SSR_A_GAIN);
  wire a_rst    = (paddr == `SSR_A_RESTART);
  wire a_cmd    = (paddr == `SSR_A_CMD);
  wire a_stat   = (paddr == `SSR_A_STATUS);
  wire a_istat  = (paddr == `SSR_A_IRQ_STAT);
  wire a_imask  = (paddr == `SSR_A_IRQ_MASK);
  wire mapped   = a_sel | a_limit | a_gain | a_rst | a_cmd | a_stat | a_istat | a_imask;
  wire fault_rst = fault_reset_input || keypad_reset || (wr_en && a_cmd && pwdata[0]);

  wire [31:0] rd_mux =
    a_sel   ? {11'h000, relay_output_select, 3'h0, transistor_output_select,
               4'h0, search_trigger_select} :
    a_limit ? {motor_rated_current, 8'h00, search_current_limit} :
    a_gain  ? {2'h0, search_integral_gain, 2'h0, search_prop_gain} :
    a_rst   ? {6'h00, restart_delay_time, 12'h000, restart_attempt_count} :
    a_stat  ? {21'h00_0000, undervoltage_trip, search_active, auto_off,
               remaining, 1'b0, state} :
    a_istat ? {26'h000_0000, irq_stat} :
    a_imask ? {26'h000_0000, irq_mask} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable) ? rd_mux : 32'h0000_0000;
    end
  end

  // writes clamp to the legal range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      search_trigger_select    <= `SSR_RST_SEL;
      transistor_output_select <= `SSR_RST_TSEL;
      relay_output_select      <= `SSR_RST_RSEL;
      search_current_limit     <= `SSR_RST_LIMIT;
      motor_rated_current      <= `SSR_RST_RATED;
      search_prop_gain         <= `SSR_RST_KP;
      search_integral_gain     <= `SSR_RST_KI;
      restart_attempt_count    <= `SSR_RST_COUNT;
      restart_delay_time       <= `SSR_RST_DELAY;
      irq_mask                 <= '0;
    end else if (wr_en) begin
      if (a_sel) begin
        search_trigger_select    <= pwdata[3:0];
        transistor_output_select <= 5'(clamp({11'h000, pwdata[`SSR_F_TSEL_LO +: 5]},
                                             16'h0000, {11'h000, `SSR_MAX_OSEL}));
        relay_output_select      <= 5'(clamp({11'h000, pwdata[`SSR_F_RSEL_LO +: 5]},
                                             16'h0000, {11'h000, `SSR_MAX_OSEL}));
      end
      if (a_limit) begin
        search_current_limit <= 8'(clamp({8'h00, pwdata[7:0]}, {8'h00, `SSR_MIN_LIMIT},
                                         {8'h00, `SSR_MAX_LIMIT}));
        motor_rated_current  <= pwdata[`SSR_F_RATED_LO +: 16];
      end
      if (a_gain) begin
        search_prop_gain     <= 14'(clamp({2'h0, pwdata[13:0]}, 16'h0000,
                                          {2'h0, `SSR_MAX_GAIN}));
        search_integral_gain <= 14'(clamp({2'h0, pwdata[`SSR_F_KI_LO +: 14]}, 16'h0000,
                                          {2'h0, `SSR_MAX_GAIN}));
      end
      if (a_rst) begin
        restart_attempt_count <= 4'(clamp({12'h000, pwdata[3:0]}, 16'h0000,
                                          {12'h000, `SSR_MAX_COUNT}));
        restart_delay_time    <= 10'(clamp({6'h00, pwdata[`SSR_F_DELAY_LO +: 10]},
                                           16'h0000, {6'h00, `SSR_MAX_DELAY}));
      end
      if (a_imask) irq_mask <= pwdata[5:0];
    end
  end

  // ==========================================
  // search current loop
  wire [23:0] cur_lim  = (motor_rated_current * search_current_limit) / `SSR_PERCENT;
  wire        over_lim = {8'h00, output_current} > cur_lim;
  wire [23:0] err_pos  = over_lim ? 24'h00_0000 : (cur_lim - {8'h00, output_current});
  wire [37:0] prod_p   = err_pos * search_prop_gain;
  wire [37:0] prod_i   = err_pos * search_integral_gain;
  wire [15:0] step_p   = (|prod_p[37:26]) ? 16'hFFFF : prod_p[25:10];
  wire [16:0] step_sum = {1'b0, step_p} + {1'b0, integ[31:16]} + 17'h0_0001;
  wire [17:0] volt_sum = {2'b00, out_volt} + {1'b0, step_sum};
  wire [15:0] volt_up  = (volt_sum >= {2'b00, nominal_volt}) ? nominal_volt : volt_sum[15:0];
  wire [15:0] freq_dn  = (out_freq > `SSR_FREQ_STEP) ? out_freq - `SSR_FREQ_STEP : 16'h0000;
  wire        at_nom   = out_volt >= nominal_volt;
  wire [15:0] run_goal = resume_hold ? saved_freq : target_freq;

  // ==========================================
  // restart timers
  wire delay_done, delay_busy, free_done, free_busy;
  wire can_retry   = (remaining != 4'h0) && !auto_off;
  wire trip_now    = trip_fault && (state == SSR_RUN || state == SSR_SEARCH);
  wire auto_go     = (state == SSR_TRIP) && delay_done && can_retry && !fault_rst;
  wire quiet       = !power_lost && !emergency_stop_input && !trip_fault;

  ssr_timer #(.TICK_CYC(TICK_CYC), .W(10)) u_delay (
    .clk    (pclk),
    .rst_n  (presetn),
    .start  (trip_now && can_retry),
    .load   (restart_delay_time),
    .cancel (fault_rst || state == SSR_LOCK || state == SSR_HOLD),
    .busy   (delay_busy),
    .done   (delay_done)
  );

  ssr_timer #(.TICK_CYC(TICK_CYC), .W(10)) u_free (
    .clk    (pclk),
    .rst_n  (presetn),
    .start  (auto_go),
    .load   (`SSR_TRIPFREE),
    .cancel (trip_now || !quiet),
    .busy   (free_busy),
    .done   (free_done)
  );

  // ==========================================
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      SSR_IDLE: begin
        if (run_cmd) next_state = ((power_on_start && search_trigger_select[3]) ||
                                   search_trigger_select[0]) ? SSR_SEARCH : SSR_RUN;
      end
      SSR_RUN: begin
        if (!run_cmd) next_state = SSR_IDLE;
      end
      SSR_SEARCH: begin
        if (at_nom) next_state = SSR_RUN;
      end
      SSR_HOLD: begin
        if (!power_lost) next_state = search_trigger_select[2] ? SSR_SEARCH : SSR_IDLE;
      end
      SSR_TRIP: begin
        if (fault_rst) next_state = !run_cmd ? SSR_IDLE :
                                    (search_trigger_select[1] ? SSR_SEARCH : SSR_RUN);
        else if (auto_go) next_state = SSR_SEARCH;
      end
      SSR_LOCK: begin
        if (fault_rst && !emergency_stop_input) next_state = SSR_IDLE;
      end
      default: next_state = SSR_IDLE;
    endcase
    if (state != SSR_LOCK) begin
      if (emergency_stop_input) next_state = SSR_LOCK;
      else if (power_lost) next_state = SSR_HOLD;
      else if (trip_now) next_state = SSR_TRIP;
    end
  end

  wire enter_search = (next_state == SSR_SEARCH) && (state != SSR_SEARCH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= SSR_IDLE;
      out_freq    <= 16'h0000;
      out_volt    <= 16'h0000;
      integ       <= 32'h0000_0000;
      saved_freq  <= 16'h0000;
      resume_hold <= 1'b0;
    end else begin
      state <= next_state;
      if (enter_search) begin
        out_freq    <= (state == SSR_IDLE) ? target_freq : saved_freq;
        out_volt    <= 16'h0000;
        integ       <= 32'h0000_0000;
        resume_hold <= (state != SSR_IDLE);
      end else if (next_state == SSR_SEARCH) begin
        if (over_lim) begin
          out_freq <= freq_dn;
        end else begin
          out_volt <= volt_up;
          integ    <= integ + {10'h000, prod_i[37:16]};
        end
      end else if (next_state == SSR_RUN) begin
        out_volt <= nominal_volt;
        if (out_freq < run_goal) out_freq <= out_freq + `SSR_FREQ_STEP;
        else if (out_freq > run_goal) out_freq <= freq_dn;
        else resume_hold <= 1'b0;
      end else if (next_state == SSR_IDLE || next_state == SSR_LOCK) begin
        out_freq <= 16'h0000;
        out_volt <= 16'h0000;
      end
      if (state == SSR_RUN && !resume_hold) saved_freq <= out_freq;
    end
  end

  // ==========================================
  // attempt counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= `SSR_RST_COUNT;
      auto_off  <= 1'b0;
    end else begin
      if (fault_rst || free_done) remaining <= restart_attempt_count;
      else if (auto_go) remaining <= remaining - 4'h1;
      // a trip with no attempts left wins over a reload in the same cycle
      if (trip_now && !can_retry) auto_off <= 1'b1;
      else if (fault_rst || free_done) auto_off <= 1'b0;
    end
  end

  // ==========================================
  // status outputs and interrupts
  wire       in_search = (next_state == SSR_SEARCH);
  wire [5:0] irq_set   = {auto_go, trip_now && !can_retry, power_lost && !undervoltage_trip,
                          trip_now, in_search && state == SSR_SEARCH && !in_search,
                          enter_search};
  // clear only what the read returned; later events survive
  wire [5:0] next_stat = (rd_en && a_istat) ? (irq_set | (irq_stat & ~prdata[5:0])) :
                         (irq_stat | irq_set);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_hold              <= 1'b0;
      undervoltage_trip        <= 1'b0;
      search_active            <= 1'b0;
      transistor_status_output <= 1'b0;
      relay_status_output      <= 1'b0;
      irq_stat                 <= '0;
      irq                      <= 1'b0;
    end else begin
      output_hold              <= (next_state == SSR_HOLD) || (next_state == SSR_TRIP) ||
                                  (next_state == SSR_LOCK);
      undervoltage_trip        <= (next_state == SSR_HOLD);
      search_active            <= in_search;
      transistor_status_output <= flags_search(transistor_output_select) && in_search;
      relay_status_output      <= flags_search(relay_output_select) && in_search;
      irq_stat                 <= next_stat;
      irq                      <= |(next_stat & irq_mask);
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_uv_trip_hold: assert property (
    power_lost && !emergency_stop_input && state != SSR_LOCK
      |=> undervoltage_trip && output_hold && state == SSR_HOLD)
    else $error("undervoltage trip not raised");
  chk_over_freq_dn: assert property (
    state == SSR_SEARCH && over_lim && quiet && !at_nom && out_freq > 16'h0001
      |=> out_freq == $past(out_freq) - 16'h0001 && out_volt == $past(out_volt))
    else $error("over limit did not lower frequency");
  chk_under_volt_up: assert property (
    state == SSR_SEARCH && !over_lim && quiet && !at_nom
      |=> out_volt > $past(out_volt) && out_freq == $past(out_freq))
    else $error("under limit did not raise voltage");
  chk_search_exit_run: assert property (
    state == SSR_SEARCH && at_nom && quiet |=> state == SSR_RUN ##1 !search_active)
    else $error("search did not end at nominal");
  chk_status_follow: assert property (
    transistor_output_select == 5'h0F && state == SSR_SEARCH && quiet && !at_nom
      |=> transistor_status_output)
    else $error("status output missed search");
  chk_count_dec: assert property (
    auto_go && quiet |=> remaining == $past(remaining) - 4'h1 && state == SSR_SEARCH)
    else $error("attempt count not decremented");
  chk_reset_reload: assert property (
    fault_rst && !trip_now |=> remaining == $past(restart_attempt_count) && !auto_off)
    else $error("fault reset did not reload count");
  chk_estop_stay: assert property (
    state == SSR_LOCK && !fault_rst |=> state == SSR_LOCK)
    else $error("restarted out of emergency stop");
  chk_no_retry_empty: assert property (
    trip_now && remaining == 4'h0 && !fault_rst |=> auto_off && !delay_busy)
    else $error("auto restart not disabled");
  chk_cfg_ranges: assert property (
    search_current_limit >= 8'h50 && search_current_limit <= 8'hC8 &&
      restart_attempt_count <= 4'hA && search_prop_gain <= 14'h270F)
    else $error("configuration out of range");

endmodule

`default_nettype wire

// ### tb/ssr_motor_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// motor: current follows load and voltage
module ssr_motor_model (
  input  wire logic        pclk,           // system clock
  input  wire logic        presetn,        // async reset, low
  input  wire logic [15:0] out_volt,       // drive voltage
  input  wire logic        heavy,          // shaft load high
  output logic      [15:0] output_current  // measured current
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_current <= 16'h0000;
    end else if (heavy) begin
      output_current <= 16'h00C8;
    end else begin
      output_current <= 16'h0032 + {4'h0, out_volt[15:4]};
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssr_cfg.svh"

module tb_top;
  import ssr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [15:0] cur, of, ov, f, v;
  logic [15:0] tf = 16'h0064, nv = 16'h0028;
  logic        run = 0, pos = 0, pl = 0, trp = 0, es = 0, frs = 0, kr = 0, heavy = 0;
  logic        pready, pslverr, hold, uv, sa, tso, rso, irq, e;
  int          error_cnt = 0, check_count = 0, cyc = 0;

  always #10 pclk = ~pclk;

  ssr_core #(.TICK_CYC(4)) i_ssr_core (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_current(cur), .target_freq(tf), .nominal_volt(nv), .run_cmd(run),
    .power_on_start(pos), .power_lost(pl), .trip_fault(trp), .emergency_stop_input(es),
    .fault_reset_input(frs), .keypad_reset(kr), .out_freq(of), .out_volt(ov),
    .output_hold(hold), .undervoltage_trip(uv), .search_active(sa),
    .transistor_status_output(tso), .relay_status_output(rso), .irq(irq));

  ssr_motor_model i_ssr_motor_model (
    .pclk(pclk), .presetn(presetn), .out_volt(ov), .heavy(heavy), .output_current(cur));

  // ==========================================
  // shared tasks
  task close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    // only the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task stc(input string n, input logic [31:0] m, input logic [31:0] x);
    xf(`SSR_A_STATUS, 0, 32'h0000_0000);
    chk(n, x, r & m);
  endtask

  task ws(input logic lvl);
    int n;
    n = 0;
    while (sa !== lvl && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("search_active", {31'h0, lvl}, {31'h0, sa});
  endtask

  task trip();
    @(posedge pclk) trp <= 1;
    @(posedge pclk) trp <= 0;
  endtask

  // ==========================================
  // scenarios
  task t_defaults();
    xf(`SSR_A_SEL, 0, 0); chk("sel", 32'h0011_0C00, r);
    xf(`SSR_A_LIMIT, 0, 0); chk("limit", 32'h0064_0064, r);
    xf(`SSR_A_GAIN, 0, 0); chk("gain", 32'h03E8_0064, r);
    xf(`SSR_A_RESTART, 0, 0); chk("restart", 32'h000A_0000, r);
    xf(8'h20, 0, 0); chk("unmapped", 32'h1, {31'h0, e});
    xf(`SSR_A_LIMIT, 1, 32'h0064_0010); xf(`SSR_A_LIMIT, 0, 0);
    chk("limit_lo", 32'h0064_0050, r);
    xf(`SSR_A_LIMIT, 1, 32'h0064_00FF); xf(`SSR_A_LIMIT, 0, 0);
    chk("limit_hi", 32'h0064_00C8, r);
    xf(`SSR_A_LIMIT, 1, 32'h0064_0064);
    xf(`SSR_A_GAIN, 1, 32'h3FFF_3FFF); xf(`SSR_A_GAIN, 0, 0);
    chk("gain_hi", 32'h270F_270F, r);
    xf(`SSR_A_RESTART, 1, 32'h03FF_000F); xf(`SSR_A_RESTART, 0, 0);
    chk("restart_hi", 32'h0258_000A, r);
  endtask

  task t_search();
    xf(`SSR_A_GAIN, 1, 32'h0000_0000);
    xf(`SSR_A_SEL, 1, 32'h000F_0F01);
    heavy <= 1;
    run <= 1;
    ws(1);
    chk("tso", 1, {31'h0, tso}); chk("rso", 1, {31'h0, rso});
    repeat (3) @(posedge pclk);
    f = of; v = ov;
    repeat (3) @(posedge pclk);
    chk("volt_held", {16'h0, v}, {16'h0, ov});
    chk("freq_down", {16'h0, f - 16'h3}, {16'h0, of});
    heavy <= 0;
    repeat (3) @(posedge pclk);
    f = of; v = ov;
    repeat (2) @(posedge pclk);
    chk("freq_stop", {16'h0, f}, {16'h0, of}); chk("volt_up", 1, {31'h0, ov > v});
    ws(0);
    chk("volt_nom", {16'h0, nv}, {16'h0, ov});
    stc("run", 32'h7, 32'h1);
  endtask

  task t_restart();
    int n;
    xf(`SSR_A_RESTART, 1, 32'h0002_0002);
    xf(`SSR_A_CMD, 1, 32'h0000_0001);
    stc("remain2", 32'hF0, 32'h20);
    xf(`SSR_A_IRQ_MASK, 1, 32'h0000_0030);
    xf(`SSR_A_IRQ_STAT, 0, 0);
    trip();
    @(posedge pclk);
    chk("hold", 1, {31'h0, hold});
    n = 1;
    while (sa !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("delay", 1, {31'h0, n >= 8 && n < 100});
    stc("remain1", 32'hF0, 32'h10);
    chk("irq_rst", 1, {31'h0, irq});
    xf(`SSR_A_IRQ_STAT, 0, 0); chk("irq_b5", 32'h20, r & 32'h20);
    xf(`SSR_A_IRQ_STAT, 0, 0); chk("irq_clr", 0, r & 32'h20);
    chk("irq_low", 0, {31'h0, irq});
    trip(); ws(0); ws(1);
    stc("remain0", 32'hF0, 32'h00);
    trip();
    repeat (20) @(posedge pclk);
    stc("auto_off", 32'h1F7, 32'h104);
    chk("irq_off", 1, {31'h0, irq});
    @(posedge pclk) frs <= 1;
    @(posedge pclk) frs <= 0;
    repeat (2) @(posedge pclk);
    stc("reload", 32'hF7, 32'h21);
    xf(`SSR_A_IRQ_STAT, 0, 0);
  endtask

  task t_tripfree();
    trip(); ws(0); ws(1);
    repeat (1000) @(posedge pclk);
    stc("tf_early", 32'hF0, 32'h10);
    repeat (300) @(posedge pclk);
    stc("tf_reload", 32'hF0, 32'h20);
  endtask

  task t_power();
    xf(`SSR_A_SEL, 1, 32'h000F_0F04);
    pl <= 1;
    repeat (3) @(posedge pclk);
    chk("uv", 1, {31'h0, uv}); chk("uv_hold", 1, {31'h0, hold});
    stc("hold_st", 32'h7, 32'h3);
    pl <= 0;
    ws(1);
    chk("freq_back", {16'h0, tf}, {16'h0, of});
    ws(0);
    es <= 1;
    repeat (2) @(posedge pclk);
    stc("lock", 32'h7, 32'h5);
    es <= 0;
    run <= 0;
    repeat (50) @(posedge pclk);
    stc("no_restart", 32'h7, 32'h5);
    @(posedge pclk) kr <= 1;
    @(posedge pclk) kr <= 0;
    repeat (2) @(posedge pclk);
    stc("unlock", 32'h7, 32'h0);
  endtask

  task t_modes();
    xf(`SSR_A_SEL, 1, 32'h000F_0F08);
    run <= 1;
    pos <= 1;
    @(posedge pclk) pos <= 0;
    ws(1);
    xf(`SSR_A_RESTART, 1, 32'h0002_0000);
    xf(`SSR_A_CMD, 1, 32'h0000_0001);
    trip();
    repeat (5) @(posedge pclk);
    stc("off_zero", 32'h107, 32'h104);
    xf(`SSR_A_SEL, 1, 32'h000F_0F02);
    xf(`SSR_A_CMD, 1, 32'h0000_0001);
    ws(1);
  endtask

  // ==========================================
  // run control
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_defaults();
    t_search();
    t_restart();
    t_tripfree();
    t_power();
    t_modes();
    close_out();
  end
endmodule
`default_nettype wire
